//--- hw/srof_regs.sv
// Synthesizer ratio, output gate and global frequency trim registers.
// Assumes the serial port engine on sys_clk_i presents decoded byte
// accesses: one-cycle write and read strobes with a 7-bit address.
`timescale 1ns/1ps

module srof_regs
    import srof_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic [15:0] pll1_fec_numerator_o,
    output logic [15:0] pll1_fec_denominator_o,
    output logic pll0_out_en_o,
    output logic pll1_out_en_o,
    output logic [31:0] global_frequency_trim_o
);

    // ==========================================================
    // Decode
    logic wr_frac;
    logic wr_trim;
    logic wr_gate;
    logic [1:0] frac_lane;
    logic [1:0] trim_lane;

    assign wr_frac = reg_wr_i && srof_hit(reg_addr_i, SROF_FRACTION_OFS);
    assign wr_trim = reg_wr_i && srof_hit(reg_addr_i, SROF_TRIM_OFS);
    assign wr_gate = reg_wr_i && (reg_addr_i == SROF_GATE_OFS);
    assign frac_lane = srof_lane(reg_addr_i, SROF_FRACTION_OFS);
    assign trim_lane = srof_lane(reg_addr_i, SROF_TRIM_OFS);

    // ==========================================================
    // Staged bytes of the multi-byte registers
    // Partial writes must never reach the synthesizer: a half-updated
    // ratio or trim would make a frequency jump to an unintended value.
    logic [31:0] frac_stage_r;
    logic [31:0] trim_stage_r;
    logic [3:0] frac_seen_r;
    logic [3:0] trim_seen_r;
    logic [3:0] frac_seen_nxt;
    logic [3:0] trim_seen_nxt;

    always_comb begin
        frac_seen_nxt = frac_seen_r;
        trim_seen_nxt = trim_seen_r;
        if (wr_frac) begin
            frac_seen_nxt[frac_lane] = 1'b1;
        end
        if (wr_trim) begin
            trim_seen_nxt[trim_lane] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            frac_stage_r <= SROF_FRACTION_RST;
            trim_stage_r <= SROF_TRIM_RST;
        end else begin
            if (wr_frac) begin
                frac_stage_r[8*frac_lane +: 8] <= reg_wdata_i;
            end
            if (wr_trim) begin
                trim_stage_r[8*trim_lane +: 8] <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            frac_seen_r <= 4'h0;
            trim_seen_r <= 4'h0;
        end else begin
            frac_seen_r <= (&frac_seen_nxt) ? 4'h0 : frac_seen_nxt;
            trim_seen_r <= (&trim_seen_nxt) ? 4'h0 : trim_seen_nxt;
        end
    end

    // ==========================================================
    // Live registers
    logic [31:0] fraction_r;
    logic [31:0] trim_r;
    logic [SROF_GATE_W-1:0] gate_r;
    logic [31:0] frac_merge;
    logic [31:0] trim_merge;

    always_comb begin
        frac_merge = frac_stage_r;
        trim_merge = trim_stage_r;
        if (wr_frac) begin
            frac_merge[8*frac_lane +: 8] = reg_wdata_i;
        end
        if (wr_trim) begin
            trim_merge[8*trim_lane +: 8] = reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            fraction_r <= SROF_FRACTION_RST;
        end else if (wr_frac && (&frac_seen_nxt)) begin
            fraction_r <= frac_merge;
        end
    end

    // trim commit, two's complement kept verbatim
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            trim_r <= SROF_TRIM_RST;
        end else if (wr_trim && (&trim_seen_nxt)) begin
            trim_r <= trim_merge;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            gate_r <= SROF_GATE_RST[SROF_GATE_W-1:0];
        end else if (wr_gate) begin
            gate_r <= reg_wdata_i[SROF_GATE_W-1:0];
        end
    end

    // ==========================================================
    // Control words to the synthesizers
    // Ratio fields are passed unaltered; the datapath forms
    // base_rate * base_multiplier * SROF_FREQ_SCALE * num / den.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pll1_fec_numerator_o <= SROF_FRACTION_RST[SROF_NUM_LSB +: 16];
            pll1_fec_denominator_o <= SROF_FRACTION_RST[SROF_DEN_LSB +: 16];
        end else begin
            pll1_fec_numerator_o <= fraction_r[SROF_NUM_LSB +: SROF_FIELD_W];
            pll1_fec_denominator_o <= fraction_r[SROF_DEN_LSB +: SROF_FIELD_W];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pll0_out_en_o <= SROF_GATE_RST[SROF_GATE_SYN0];
            pll1_out_en_o <= SROF_GATE_RST[SROF_GATE_SYN1];
        end else begin
            pll0_out_en_o <= gate_r[SROF_GATE_SYN0];
            pll1_out_en_o <= gate_r[SROF_GATE_SYN1];
        end
    end

    // One broadcast word; every synthesizer scales by 1 + trim / 2^32.
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            global_frequency_trim_o <= SROF_TRIM_RST;
        end else begin
            global_frequency_trim_o <= trim_r;
        end
    end

    // ==========================================================
    // Read-back of live values; unmapped addresses read zero
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (srof_hit(reg_addr_i, SROF_FRACTION_OFS)) begin
            rd_byte = fraction_r[8*frac_lane +: 8];
        end else if (srof_hit(reg_addr_i, SROF_TRIM_OFS)) begin
            rd_byte = trim_r[8*trim_lane +: 8];
        end else if (reg_addr_i == SROF_GATE_OFS) begin
            rd_byte = {6'h00, gate_r};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_byte;
            end
        end
    end

endmodule

//--- hw/srof_pkg.sv
// Constants for the synthesizer ratio, output gate and frequency trim bank.
// Assumes a byte-wide register port with 7-bit addresses, one clock domain.
//
// Operation
// - Fraction register: denominator in bits 15:0, numerator in bits 31:16.
// - Synth frequency equals base rate times multiplier times 16 times num/den.
// - Gate bit 0 enables synth 0, bit 1 synth 1; resets 0x03.
// - Trim is 32-bit two's complement, step two to minus 32 of nominal.
// - One trim value steers the centre frequency of every synthesizer.
// - Output frequency is initial frequency times one plus trim over 2^32.
// - Trim resets to 0x046AAAAB, correcting 24.576 MHz nominal to 25 MHz.
package srof_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [6:0] SROF_FRACTION_OFS = 7'h5C;
    localparam logic [6:0] SROF_GATE_OFS = 7'h71;
    localparam logic [6:0] SROF_TRIM_OFS = 7'h73;

    // ==========================================================
    // Field positions
    localparam int SROF_DEN_LSB = 0;
    localparam int SROF_NUM_LSB = 16;
    localparam int SROF_FIELD_W = 16;
    localparam int SROF_GATE_W = 2;
    localparam int SROF_GATE_SYN0 = 0;
    localparam int SROF_GATE_SYN1 = 1;

    // ==========================================================
    // Reset values
    localparam logic [31:0] SROF_FRACTION_RST = 32'h0001_0001;
    localparam logic [7:0] SROF_GATE_RST = 8'h03;
    localparam logic [31:0] SROF_TRIM_RST = 32'h046A_AAAB;

    // Fixed frequency scale of the synthesizer word
    localparam int SROF_FREQ_SCALE = 16;

    // Byte lane of a 4-byte register; lane 3 is the MSB at the base address
    function automatic logic [1:0] srof_lane(input logic [6:0] addr,
                                             input logic [6:0] base);
        logic [6:0] diff;
        diff = addr - base;
        srof_lane = 2'd3 - diff[1:0];
    endfunction

    function automatic logic srof_hit(input logic [6:0] addr,
                                      input logic [6:0] base);
        srof_hit = (addr >= base) && (addr <= base + 7'd3);
    endfunction

endpackage

//--- verif/srof_regs_asserts.sv
// Checker for the ratio, gate and trim register bank.
// Assumes it is bound to srof_regs and sees only its ports.
`timescale 1ns/1ps
module srof_regs_asserts
    import srof_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic [15:0] pll1_fec_numerator_o,
    input wire logic [15:0] pll1_fec_denominator_o,
    input wire logic pll0_out_en_o,
    input wire logic pll1_out_en_o,
    input wire logic [31:0] global_frequency_trim_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // ==========================================================
    // Read port and gate
    property p_rd_valid;
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("no valid");
    property p_no_valid;
        !reg_rd_i |=> !reg_rvalid_o;
    endproperty
    a_no_valid: assert property (p_no_valid) else $error("stray valid");
    property p_gate;
        reg_wr_i && reg_addr_i == SROF_GATE_OFS |-> ##2
            {pll1_out_en_o, pll0_out_en_o} == 2'($past(reg_wdata_i, 2));
    endproperty
    a_gate: assert property (p_gate) else $error("gate wrong");
    property p_gate_rsvd;
        reg_rd_i && reg_addr_i == SROF_GATE_OFS |=> reg_rdata_o[7:2] == 6'h0;
    endproperty
    a_gate_rsvd: assert property (p_gate_rsvd) else $error("rsvd set");
    property p_unmapped;
        reg_rd_i && reg_addr_i == 7'h72 |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole read");
    // ==========================================================
    // Control words
    property p_rst_vals;
        $rose(resetn_i) |-> global_frequency_trim_o == SROF_TRIM_RST &&
            {pll1_fec_numerator_o, pll1_fec_denominator_o} == 32'h0001_0001;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset val");
    // Any change needs a completing write two edges earlier
    property p_trim_hold;
        !reg_wr_i ##1 !reg_wr_i |=> $stable(global_frequency_trim_o);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim moved");
    property p_frac_hold;
        !reg_wr_i ##1 !reg_wr_i |=> $stable(pll1_fec_numerator_o) &&
            $stable(pll1_fec_denominator_o);
    endproperty
    a_frac_hold: assert property (p_frac_hold) else $error("frac moved");
endmodule

bind srof_regs srof_regs_asserts asrt_u (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .pll1_fec_numerator_o(pll1_fec_numerator_o),
    .pll1_fec_denominator_o(pll1_fec_denominator_o),
    .pll0_out_en_o(pll0_out_en_o), .pll1_out_en_o(pll1_out_en_o),
    .global_frequency_trim_o(global_frequency_trim_o));

//--- verif/synth_ratio_offset_regs_bench.sv
// Self-checking bench for the ratio, gate and trim register bank.
// Assumes srof_regs and its checker are compiled before this file.
`timescale 1ns/1ps
module synth_ratio_offset_regs_bench;
    import srof_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [6:0] a_i = 7'h00;
    logic [7:0] d_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] num;
    logic [15:0] den;
    logic en0;
    logic en1;
    logic [31:0] trim;
    int n_mismatch = 0;
    int n_tests = 0;
    srof_regs dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(a_i), .reg_wdata_i(d_i), .reg_wr_i(wr_i), .reg_rd_i(rd_i),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .pll1_fec_numerator_o(num),
        .pll1_fec_denominator_o(den), .pll0_out_en_o(en0),
        .pll1_out_en_o(en1), .global_frequency_trim_o(trim));
    always #2.5 sys_clk_i = ~sys_clk_i;
    // ==========================================================
    // Bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        tick(1);
        wr_i = 1'b1;
        a_i = a;
        d_i = d;
        tick(1);
        wr_i = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        tick(1);
        rd_i = 1'b1;
        a_i = a;
        tick(1);
        rd_i = 1'b0;
        chk({31'h0, rvalid}, 32'h1);
        chk({24'h0, rdata}, {24'h0, exp});
    endtask
    // MSB byte sits at the base address
    task automatic wr32(input logic [6:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) wr(a + 7'(i), d[31-8*i -: 8]);
    endtask
    task automatic rd32(input logic [6:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) rd(a + 7'(i), d[31-8*i -: 8]);
    endtask
    task automatic wrap_up;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk(trim, 32'h046A_AAAB);
        chk({num, den}, 32'h0001_0001);
        chk({30'h0, en1, en0}, 32'h3);
        rd32(SROF_TRIM_OFS, 32'h046A_AAAB);
        rd(SROF_GATE_OFS, 8'h03);
    endtask
    task automatic t_gate;
        wr(SROF_GATE_OFS, 8'hFD);
        tick(2);
        chk({30'h0, en1, en0}, 32'h1);
        rd(SROF_GATE_OFS, 8'h01);
        wr(SROF_GATE_OFS, 8'h02);
        tick(2);
        chk({30'h0, en1, en0}, 32'h2);
    endtask
    task automatic t_trim;
        wr(SROF_TRIM_OFS, 8'h80);
        wr(SROF_TRIM_OFS + 7'h1, 8'h00);
        wr(SROF_TRIM_OFS + 7'h2, 8'h00);
        tick(2);
        chk(trim, 32'h046A_AAAB);
        rd(SROF_TRIM_OFS, 8'h04);
        wr(SROF_TRIM_OFS + 7'h3, 8'h01);
        tick(2);
        chk(trim, 32'h8000_0001);
        rd32(SROF_TRIM_OFS, 32'h8000_0001);
    endtask
    task automatic t_frac;
        wr32(SROF_FRACTION_OFS, 32'h00FF_00ED);
        tick(2);
        chk({num, den}, 32'h00FF_00ED);
        rd32(SROF_FRACTION_OFS, 32'h00FF_00ED);
        wr(7'h72, 8'h5A);
        rd(7'h72, 8'h00);
        chk(trim, 32'h8000_0001);
    endtask
    // Slow oscillator at -2%: trim is (1/0.98 - 1) * 2^32, rounded
    task automatic t_ppm;
        wr32(SROF_TRIM_OFS, 32'h0539_782A);
        tick(2);
        chk(trim, 32'h0539_782A);
        rd32(SROF_TRIM_OFS, 32'h0539_782A);
        // Just inside the -5% limit, sign bit must survive intact
        wr32(SROF_TRIM_OFS, 32'hF333_3334);
        tick(2);
        chk(trim, 32'hF333_3334);
        rd32(SROF_TRIM_OFS, 32'hF333_3334);
    endtask
    // Mid-run reset must also drop lanes staged before it
    task automatic t_rerst;
        wr(SROF_TRIM_OFS, 8'h12);
        wr(SROF_TRIM_OFS + 7'h1, 8'h34);
        wr(SROF_TRIM_OFS + 7'h2, 8'h56);
        wr(SROF_GATE_OFS, 8'h00);
        resetn_i = 1'b0;
        tick(3);
        resetn_i = 1'b1;
        t_reset();
        wr(SROF_TRIM_OFS + 7'h3, 8'h78);
        tick(2);
        chk(trim, 32'h046A_AAAB);
        rd(SROF_TRIM_OFS + 7'h3, 8'hAB);
    endtask
    initial begin
        tick(3);
        resetn_i = 1'b1;
        t_reset();
        t_gate();
        t_trim();
        t_frac();
        t_ppm();
        t_rerst();
        wrap_up();
    end
    // Run needs about 130 cycles; this leaves a wide margin
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule
